// ===== fetch_unit_map.vh
`ifndef FETCH_UNIT_MAP_VH
`define FETCH_UNIT_MAP_VH

// ****
// Register indices (word index on the register port)
// ****
`define REG_CTRL         6'h00
`define REG_STATUS       6'h01
`define REG_START_ADDR   6'h02
`define REG_STRIDE       6'h03
`define REG_LINE_DIM     6'h04
`define REG_DEPTH        6'h05
`define REG_COMP_WIDTH   6'h06
`define REG_COMP_POS     6'h07
`define REG_FIXED_COLOUR 6'h08
`define REG_OUT_DIM      6'h09
`define REG_WINDOW_POS   6'h0A
`define REG_STEP         6'h0B
`define REG_HOLE_POS     6'h0C
`define REG_HOLE_DIM     6'h0D
`define REG_KEY          6'h0E
`define REG_RLE_LEN      6'h0F
`define REG_AXI_CFG      6'h10

// ****
// Control bits
// ****
`define CTRL_START        0
`define CTRL_RLE_ON       1
`define CTRL_BYTE_FLIP    2
`define CTRL_HDR_VARIANT  3
`define CTRL_HOLE_INVERT  4
`define CTRL_OUTSIDE_SEL  5
`define CTRL_HOLE_SEL     6
`define CTRL_GALPHA_ON    7
`define CTRL_SCALE_LO     8
`define CTRL_KEY_ON       10
`define CTRL_WIDTH        11

// ****
// Selection codes and reset values
// ****
`define FILL_WITH_FIXED   1'b0
`define SCALE_NONE        2'h0
`define SCALE_BY_ALPHA    2'h1
`define SCALE_BY_FIXED    2'h2
`define RST_BURST_LEN     5'h04
`define RST_OUT_BUFS      8'h04
`define RST_DEPTH         6'h20
`define RST_STEP          32'h0001_0001
`define RST_COMP_WIDTH    16'h8888
`define RST_COMP_POS      32'h1810_0800

// ****
// AXI read channel constants
// ****
`define AXI_SIZE_WORD     3'h2
`define AXI_BURST_INCR    2'h1

`endif

// ===== burst_word_store.v
`timescale 1ns/1ns

// ****
// Landing store for one read burst
// ****
module burst_word_store #(
	parameter WIDTH = 32,
	parameter AW    = 4
) (
	input  wire             core_clk_i,
	input  wire             wr_en_i,
	input  wire [AW-1:0]    wr_idx_i,
	input  wire [WIDTH-1:0] wr_data_i,
	input  wire [AW-1:0]    rd_idx_i,
	output reg  [WIDTH-1:0] rd_data_o
);
	reg [WIDTH-1:0] mem_q [0:(1<<AW)-1];

	always @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_idx_i] <= wr_data_i;
		end
		rd_data_o <= mem_q[rd_idx_i];
	end
endmodule // burst_word_store

// ===== display_buffer_fetch_unit.v
`timescale 1ns/1ns
`include "fetch_unit_map.vh"

// Summary of operation
// RULE1 - Sprite variant: software uses burst 2, 8 buffers
// RULE2 - Decoder variant: 4/4 horizontal, 1/16 swapped
// RULE3 - Source located by base, stride, lines, width, depth
// RULE4 - Software avoids 24 bpp with negative steps
// RULE5 - Components extracted by own width and position
// RULE6 - Zero-width component takes its fixed value
// RULE7 - Output frame size equals clip window
// RULE8 - Hole rectangle with optional inversion
// RULE9 - Outside and hole pixels take selected fill
// RULE10 - Global alpha scales output alpha when enabled
// RULE11 - Offset -1, step 0 gives memoryless fixed frame
// RULE12 - Alpha scaling multiplies colour by own alpha
// RULE13 - Fixed scaling multiplies by factor, 255 is one
// RULE14 - Scaling follows global alpha
// RULE15 - Colour key replaces alpha before scaling
// RULE16 - Decoder reads length words from base address
// RULE17 - Stride ignored while decoding
// RULE18 - Default run format, optional byte order flip
// RULE19 - Header variant changes run header layout
// RULE20 - Software disables clipping for encoded buffers
// RULE21 - Step -1 from right edge flips lines
// RULE22 - Bursts of set length, outstanding limited
// RULE23 - Raster output on valid/ready, never drops
module display_buffer_fetch_unit #(
	parameter BURST_AW = 4
) (
	input  wire        core_clk_i,
	input  wire        reset_i,
	input  wire [5:0]  reg_addr_i,
	input  wire [31:0] reg_wdata_i,
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	output reg  [31:0] reg_rdata_o,
	output reg  [31:0] m_axi_araddr_o,
	output wire [7:0]  m_axi_arlen_o,
	output wire [2:0]  m_axi_arsize_o,
	output wire [1:0]  m_axi_arburst_o,
	output wire        m_axi_arvalid_o,
	input  wire        m_axi_arready_i,
	input  wire [31:0] m_axi_rdata_i,
	input  wire        m_axi_rvalid_i,
	input  wire        m_axi_rlast_i,
	output wire        m_axi_rready_o,
	output wire        pix_valid_o,
	input  wire        pix_ready_i,
	output reg  [7:0]  pix_r_o,
	output reg  [7:0]  pix_g_o,
	output reg  [7:0]  pix_b_o,
	output reg  [7:0]  pix_a_o,
	output reg         pix_last_o
);
	localparam S_IDLE = 3'h0;
	localparam S_PIX  = 3'h1;
	localparam S_LOOK = 3'h2;
	localparam S_AR   = 3'h3;
	localparam S_R    = 3'h4;
	localparam S_MEM  = 3'h5;
	localparam S_OUT  = 3'h6;

	// ****
	// Configuration registers
	// ****
	reg [`CTRL_WIDTH-1:0] ctrl_q;
	reg [31:0] start_addr_q, stride_q, line_dim_q, fixed_q, out_dim_q, win_q, step_q;
	reg [31:0] hole_pos_q, hole_dim_q, key_q, rle_len_q, comp_pos_q;
	reg [15:0] comp_width_q, frame_cnt_q;
	reg [5:0]  depth_q;
	reg [4:0]  burst_len_cfg_q;
	reg [7:0]  outstanding_buf_cfg_q;

	// ****
	// Fetch state
	// ****
	reg [2:0]  state_q;
	reg [15:0] x_q, y_q;
	reg [29:0] req_q, tag_q;
	reg        tag_ok_q, part_q, need2_q;
	reg [1:0]  fill_q;
	reg [31:0] lo_q, raw_q, rle_pix_q, rle_ptr_q;
	reg [4:0]  bitoff_q;
	reg [BURST_AW-1:0] beat_q;
	reg [7:0]  run_left_q;
	reg        run_raw_q, hdr_phase_q;
	reg [1:0]  byte_k_q;
	reg        out_valid_q;
	wire [31:0] mem_data;

	wire [15:0] line_pixels  = line_dim_q[15:0];
	wire [15:0] line_total   = line_dim_q[31:16];
	wire [15:0] out_width    = out_dim_q[15:0];
	wire [15:0] out_height   = out_dim_q[31:16];
	wire [7:0]  fixed_alpha_value = fixed_q[31:24];
	wire        rle_decode_on = ctrl_q[`CTRL_RLE_ON];
	wire [1:0]  scale_source_sel = ctrl_q[`CTRL_SCALE_LO+1:`CTRL_SCALE_LO];
	wire        last_x = (x_q == out_width - 16'h0001);
	wire        last_y = (y_q == out_height - 16'h0001);

	// ****
	// Source coordinate and address
	// ****
	wire signed [31:0] sx = $signed({{16{win_q[15]}}, win_q[15:0]}) +
		$signed({16'h0000, x_q}) * $signed({{16{step_q[15]}}, step_q[15:0]}); // RULE21
	wire signed [31:0] sy = $signed({{16{win_q[31]}}, win_q[31:16]}) +
		$signed({16'h0000, y_q}) * $signed({{16{step_q[31]}}, step_q[31:16]});
	wire in_buf = !sx[31] && !sy[31] && (sx < {16'h0000, line_pixels}) &&
		(sy < {16'h0000, line_total}); // RULE7
	wire [16:0] hole_x_end = {1'b0, hole_pos_q[15:0]} + {1'b0, hole_dim_q[15:0]};
	wire [16:0] hole_y_end = {1'b0, hole_pos_q[31:16]} + {1'b0, hole_dim_q[31:16]};
	wire in_rect = (sx[16:0] >= {1'b0, hole_pos_q[15:0]}) && (sx[16:0] < hole_x_end) &&
		(sy[16:0] >= {1'b0, hole_pos_q[31:16]}) && (sy[16:0] < hole_y_end);
	wire in_hole = in_rect ^ ctrl_q[`CTRL_HOLE_INVERT]; // RULE8
	wire [31:0] bit_addr = sx[25:0] * depth_q;
	wire [31:0] pix_addr = start_addr_q + sy[15:0] * stride_q[15:0] +
		{bit_addr[31:5], 2'b00}; // RULE3
	wire [6:0]  bit_end = {2'b00, bit_addr[4:0]} + {1'b0, depth_q};
	wire [31:0] rle_addr = start_addr_q + rle_ptr_q; // RULE17
	wire        rle_end = (rle_ptr_q[31:2] >= rle_len_q[29:0]); // RULE16

	// ****
	// Burst cache: one burst outstanding at most
	// ****
	wire [29:0] tag_off = req_q - tag_q;
	wire        hit = tag_ok_q && (tag_off < {25'h0, burst_len_cfg_q});
	wire        may_issue = (outstanding_buf_cfg_q != 8'h00); // RULE22
	assign m_axi_arlen_o   = {3'h0, burst_len_cfg_q} - 8'h01; // RULE22
	assign m_axi_arsize_o  = `AXI_SIZE_WORD;
	assign m_axi_arburst_o = `AXI_BURST_INCR;
	assign m_axi_arvalid_o = (state_q == S_AR);
	assign m_axi_rready_o  = (state_q == S_R);
	assign pix_valid_o     = out_valid_q;

	burst_word_store #(.WIDTH(32), .AW(BURST_AW)) u_store (
		.core_clk_i (core_clk_i),
		.wr_en_i    (m_axi_rvalid_i && state_q == S_R),
		.wr_idx_i   (beat_q),
		.wr_data_i  (m_axi_rdata_i),
		.rd_idx_i   (tag_off[BURST_AW-1:0]),
		.rd_data_o  (mem_data)
	);

	// ****
	// Run header and byte picking
	// ****
	wire [1:0] byte_sel = ctrl_q[`CTRL_BYTE_FLIP] ? ~rle_addr[1:0] : rle_addr[1:0]; // RULE18
	wire [7:0] rle_byte = mem_data[byte_sel*8 +: 8];
	wire       hdr_run  = ctrl_q[`CTRL_HDR_VARIANT] ? !rle_byte[0] : rle_byte[7]; // RULE19
	wire [6:0] hdr_cnt  = ctrl_q[`CTRL_HDR_VARIANT] ? rle_byte[7:1] : rle_byte[6:0];
	wire [2:0] pix_bytes = depth_q[5:3];
	wire [63:0] two_words = {mem_data, lo_q} >> bitoff_q;

	// ****
	// Pixel processing
	// ****
	function [7:0] mul255;
		input [7:0] v;
		input [7:0] f;
		reg [16:0] t;
		reg [16:0] u;
		begin
			t = {9'h000, v} * {9'h000, f} + 17'h0_0080;
			u = t + {8'h00, t[16:8]};
			mul255 = u[15:8];
		end
	endfunction

	wire [31:0] comp_raw;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_comp
			wire [3:0]  w = comp_width_q[gi*4 +: 4];
			wire [31:0] v = (raw_q >> comp_pos_q[gi*8 +: 5]) & ~(32'hFFFF_FFFF << w); // RULE5
			wire [31:0] up = (w >= 4'h8) ? (v >> (w - 4'h8)) : (v << (4'h8 - w));
			wire [7:0]  rep = up[7:0] | (up[7:0] >> w);
			assign comp_raw[gi*8 +: 8] = (w == 4'h0) ? fixed_q[gi*8 +: 8] : rep; // RULE6
		end
	endgenerate

	wire       key_hit = ctrl_q[`CTRL_KEY_ON] && (comp_raw[23:0] == key_q[23:0]);
	wire [7:0] a_key = key_hit ? key_q[31:24] : comp_raw[31:24]; // RULE15
	wire [7:0] a_glb = ctrl_q[`CTRL_GALPHA_ON] ? mul255(a_key, fixed_alpha_value) : a_key; // RULE10
	reg  [31:0] pix_proc;
	always @* begin
		pix_proc = {a_glb, comp_raw[23:0]};
		case (scale_source_sel) // RULE14
			`SCALE_BY_ALPHA: begin // RULE12
				pix_proc = {a_glb, mul255(comp_raw[23:16], a_glb),
					mul255(comp_raw[15:8], a_glb), mul255(comp_raw[7:0], a_glb)};
			end
			`SCALE_BY_FIXED: begin // RULE13
				pix_proc = {mul255(a_glb, fixed_q[31:24]), mul255(comp_raw[23:16], fixed_q[23:16]),
					mul255(comp_raw[15:8], fixed_q[15:8]), mul255(comp_raw[7:0], fixed_q[7:0])};
			end
			default: begin
				pix_proc = {a_glb, comp_raw[23:0]};
			end
		endcase
	end
	wire        fill_sel = (fill_q == 2'h1) ? ctrl_q[`CTRL_OUTSIDE_SEL] : ctrl_q[`CTRL_HOLE_SEL];
	wire [31:0] fill_pix = (fill_sel == `FILL_WITH_FIXED) ? fixed_q : 32'h0000_0000;
	wire [31:0] out_pix  = (fill_q != 2'h0) ? fill_pix : pix_proc; // RULE9

	// ****
	// Register port
	// ****
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl_q <= {`CTRL_WIDTH{1'b0}};
			start_addr_q <= 32'h0000_0000;
			stride_q <= 32'h0000_0000;
			line_dim_q <= 32'h0000_0000;
			depth_q <= `RST_DEPTH;
			comp_width_q <= `RST_COMP_WIDTH;
			comp_pos_q <= `RST_COMP_POS;
			fixed_q <= 32'h0000_0000;
			out_dim_q <= 32'h0000_0000;
			win_q <= 32'h0000_0000;
			step_q <= `RST_STEP;
			hole_pos_q <= 32'h0000_0000;
			hole_dim_q <= 32'h0000_0000;
			key_q <= 32'h0000_0000;
			rle_len_q <= 32'h0000_0000;
			burst_len_cfg_q <= `RST_BURST_LEN;
			outstanding_buf_cfg_q <= `RST_OUT_BUFS;
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			ctrl_q[`CTRL_START] <= 1'b0;
			if (reg_wr_i) begin
				case (reg_addr_i)
					`REG_CTRL:         ctrl_q <= reg_wdata_i[`CTRL_WIDTH-1:0];
					`REG_START_ADDR:   start_addr_q <= reg_wdata_i;
					`REG_STRIDE:       stride_q <= reg_wdata_i;
					`REG_LINE_DIM:     line_dim_q <= reg_wdata_i;
					`REG_DEPTH:        depth_q <= reg_wdata_i[5:0];
					`REG_COMP_WIDTH:   comp_width_q <= reg_wdata_i[15:0];
					`REG_COMP_POS:     comp_pos_q <= reg_wdata_i;
					`REG_FIXED_COLOUR: fixed_q <= reg_wdata_i;
					`REG_OUT_DIM:      out_dim_q <= reg_wdata_i;
					`REG_WINDOW_POS:   win_q <= reg_wdata_i;
					`REG_STEP:         step_q <= reg_wdata_i;
					`REG_HOLE_POS:     hole_pos_q <= reg_wdata_i;
					`REG_HOLE_DIM:     hole_dim_q <= reg_wdata_i;
					`REG_KEY:          key_q <= reg_wdata_i;
					`REG_RLE_LEN:      rle_len_q <= reg_wdata_i;
					`REG_AXI_CFG: begin
						burst_len_cfg_q <= reg_wdata_i[4:0];
						outstanding_buf_cfg_q <= reg_wdata_i[15:8];
					end
					default: ;
				endcase
			end
			reg_rdata_o <= 32'h0000_0000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					`REG_CTRL:         reg_rdata_o <= {21'h0, ctrl_q};
					`REG_STATUS:       reg_rdata_o <= {frame_cnt_q, 15'h0, state_q != S_IDLE};
					`REG_START_ADDR:   reg_rdata_o <= start_addr_q;
					`REG_STRIDE:       reg_rdata_o <= stride_q;
					`REG_LINE_DIM:     reg_rdata_o <= line_dim_q;
					`REG_DEPTH:        reg_rdata_o <= {26'h0, depth_q};
					`REG_COMP_WIDTH:   reg_rdata_o <= {16'h0, comp_width_q};
					`REG_COMP_POS:     reg_rdata_o <= comp_pos_q;
					`REG_FIXED_COLOUR: reg_rdata_o <= fixed_q;
					`REG_OUT_DIM:      reg_rdata_o <= out_dim_q;
					`REG_WINDOW_POS:   reg_rdata_o <= win_q;
					`REG_STEP:         reg_rdata_o <= step_q;
					`REG_HOLE_POS:     reg_rdata_o <= hole_pos_q;
					`REG_HOLE_DIM:     reg_rdata_o <= hole_dim_q;
					`REG_KEY:          reg_rdata_o <= key_q;
					`REG_RLE_LEN:      reg_rdata_o <= rle_len_q;
					`REG_AXI_CFG:      reg_rdata_o <= {16'h0, outstanding_buf_cfg_q, 3'h0,
						burst_len_cfg_q};
					default:           reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****
	// Fetch sequencer
	// ****
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			state_q <= S_IDLE;
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			req_q <= 30'h0000_0000;
			tag_q <= 30'h0000_0000;
			tag_ok_q <= 1'b0;
			part_q <= 1'b0;
			need2_q <= 1'b0;
			fill_q <= 2'h0;
			lo_q <= 32'h0000_0000;
			raw_q <= 32'h0000_0000;
			rle_pix_q <= 32'h0000_0000;
			rle_ptr_q <= 32'h0000_0000;
			bitoff_q <= 5'h00;
			beat_q <= {BURST_AW{1'b0}};
			run_left_q <= 8'h00;
			run_raw_q <= 1'b0;
			hdr_phase_q <= 1'b0;
			byte_k_q <= 2'h0;
			out_valid_q <= 1'b0;
			frame_cnt_q <= 16'h0000;
			m_axi_araddr_o <= 32'h0000_0000;
			pix_r_o <= 8'h00;
			pix_g_o <= 8'h00;
			pix_b_o <= 8'h00;
			pix_a_o <= 8'h00;
			pix_last_o <= 1'b0;
		end else begin
			if (out_valid_q && pix_ready_i) begin
				out_valid_q <= 1'b0;
			end
			case (state_q)
				S_IDLE: begin
					if (ctrl_q[`CTRL_START] && out_width != 16'h0000 && out_height != 16'h0000) begin
						x_q <= 16'h0000;
						y_q <= 16'h0000;
						rle_ptr_q <= 32'h0000_0000;
						run_left_q <= 8'h00;
						tag_ok_q <= 1'b0;
						state_q <= S_PIX;
					end
				end
				S_PIX: begin
					fill_q <= 2'h0;
					if (rle_decode_on) begin // RULE16
						if (run_left_q != 8'h00 && !run_raw_q) begin
							state_q <= S_OUT;
						end else if (rle_end) begin
							fill_q <= 2'h1;
							state_q <= S_OUT;
						end else begin
							hdr_phase_q <= (run_left_q == 8'h00);
							byte_k_q <= 2'h0;
							req_q <= rle_addr[31:2];
							state_q <= S_LOOK;
						end
					end else if (!in_buf) begin
						fill_q <= 2'h1; // RULE11
						state_q <= S_OUT;
					end else if (in_hole) begin
						fill_q <= 2'h2;
						state_q <= S_OUT;
					end else begin
						req_q <= pix_addr[31:2];
						bitoff_q <= bit_addr[4:0];
						need2_q <= (bit_end > 7'h20);
						part_q <= 1'b0;
						state_q <= S_LOOK;
					end
				end
				S_LOOK: begin
					if (hit) begin
						state_q <= S_MEM;
					end else if (may_issue) begin
						tag_q <= req_q;
						tag_ok_q <= 1'b0;
						beat_q <= {BURST_AW{1'b0}};
						m_axi_araddr_o <= {req_q, 2'b00};
						state_q <= S_AR;
					end
				end
				S_AR: begin
					if (m_axi_arready_i) begin
						state_q <= S_R;
					end
				end
				S_R: begin
					if (m_axi_rvalid_i) begin
						beat_q <= beat_q + {{(BURST_AW-1){1'b0}}, 1'b1};
						if (m_axi_rlast_i) begin
							tag_ok_q <= 1'b1;
							state_q <= S_LOOK;
						end
					end
				end
				S_MEM: begin
					if (rle_decode_on && hdr_phase_q) begin
						run_left_q <= {1'b0, hdr_cnt} + 8'h01;
						run_raw_q <= !hdr_run;
						hdr_phase_q <= 1'b0;
						rle_ptr_q <= rle_ptr_q + 32'h0000_0001;
						req_q <= rle_addr[31:2];
						state_q <= S_PIX;
					end else if (rle_decode_on) begin
						rle_pix_q[byte_k_q*8 +: 8] <= rle_byte;
						rle_ptr_q <= rle_ptr_q + 32'h0000_0001;
						byte_k_q <= byte_k_q + 2'h1;
						if ({1'b0, byte_k_q} + 3'h1 >= pix_bytes) begin
							run_raw_q <= run_raw_q;
							state_q <= S_OUT;
						end else begin
							state_q <= S_PIX;
							hdr_phase_q <= 1'b0;
						end
					end else if (!part_q && need2_q) begin
						lo_q <= mem_data;
						part_q <= 1'b1;
						req_q <= req_q + 30'h0000_0001;
						state_q <= S_LOOK;
					end else begin
						raw_q <= part_q ? two_words[31:0] : (mem_data >> bitoff_q);
						state_q <= S_OUT;
					end
				end
				S_OUT: begin
					if (!out_valid_q || pix_ready_i) begin // RULE23
						out_valid_q <= 1'b1;
						pix_r_o <= out_pix[7:0];
						pix_g_o <= out_pix[15:8];
						pix_b_o <= out_pix[23:16];
						pix_a_o <= out_pix[31:24];
						pix_last_o <= last_x && last_y;
						if (rle_decode_on && run_left_q != 8'h00) begin
							run_left_q <= run_left_q - 8'h01;
						end
						if (last_x) begin
							x_q <= 16'h0000;
							y_q <= y_q + 16'h0001;
						end else begin
							x_q <= x_q + 16'h0001;
						end
						if (last_x && last_y) begin
							frame_cnt_q <= frame_cnt_q + 16'h0001;
							state_q <= S_IDLE;
						end else begin
							state_q <= S_PIX;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule // display_buffer_fetch_unit

// ===== fetch_unit_sva.sv
`timescale 1ns/1ns
`include "fetch_unit_map.vh"
// ****
// Port checker
// ****
module fetch_unit_sva (
	input wire        core_clk_i,
	input wire        reset_i,
	input wire [5:0]  reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire        reg_wr_i,
	input wire [31:0] m_axi_araddr_o,
	input wire [7:0]  m_axi_arlen_o,
	input wire [2:0]  m_axi_arsize_o,
	input wire [1:0]  m_axi_arburst_o,
	input wire        m_axi_arvalid_o,
	input wire        m_axi_arready_i,
	input wire        m_axi_rvalid_i,
	input wire        m_axi_rlast_i,
	input wire        m_axi_rready_o,
	input wire        pix_valid_o,
	input wire        pix_ready_i,
	input wire [7:0]  pix_r_o,
	input wire [7:0]  pix_g_o,
	input wire [7:0]  pix_b_o,
	input wire [7:0]  pix_a_o,
	input wire        pix_last_o
);
	reg [31:0] ctrl_q, cw_q, fc_q, dim_q, win_q, step_q, cfg_q, cnt_q;
	reg [1:0]  out_q;
	// Shadow copies; only valid while software writes when idle
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl_q <= 32'h0;
			cw_q <= {16'h0, `RST_COMP_WIDTH};
			fc_q <= 32'h0;
			dim_q <= 32'h0;
			win_q <= 32'h0;
			step_q <= `RST_STEP;
			cfg_q <= {16'h0, `RST_OUT_BUFS, 3'h0, `RST_BURST_LEN};
		end else if (reg_wr_i) begin
			case (reg_addr_i)
			`REG_CTRL: ctrl_q <= reg_wdata_i;
			`REG_COMP_WIDTH: cw_q <= reg_wdata_i;
			`REG_FIXED_COLOUR: fc_q <= reg_wdata_i;
			`REG_OUT_DIM: dim_q <= reg_wdata_i;
			`REG_WINDOW_POS: win_q <= reg_wdata_i;
			`REG_STEP: step_q <= reg_wdata_i;
			`REG_AXI_CFG: cfg_q <= reg_wdata_i;
			default: ;
			endcase
		end
	end
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			out_q <= 2'h0;
			cnt_q <= 32'h0;
		end else begin
			out_q <= out_q + {1'b0, m_axi_arvalid_o && m_axi_arready_i}
				- {1'b0, m_axi_rvalid_i && m_axi_rready_o && m_axi_rlast_i};
			if (pix_valid_o && pix_ready_i)
				cnt_q <= pix_last_o ? 32'h0 : cnt_q + 32'h1;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	sequence s_ar_wait; m_axi_arvalid_o && !m_axi_arready_i; endsequence
	sequence s_pix_wait; pix_valid_o && !pix_ready_i; endsequence
	property p_ar_hold;
		s_ar_wait |=> m_axi_arvalid_o && $stable(m_axi_araddr_o) && $stable(m_axi_arlen_o);
	endproperty
	a_ar_hold: assert property (p_ar_hold) else $error("read request changed early");
	property p_ar_len;
		m_axi_arvalid_o |-> m_axi_arlen_o == {3'h0, cfg_q[4:0]} - 8'h01
			&& m_axi_arsize_o == `AXI_SIZE_WORD && m_axi_arburst_o == `AXI_BURST_INCR;
	endproperty
	a_ar_len: assert property (p_ar_len) else $error("burst shape wrong");
	property p_one_out;
		out_q <= 2'h1 && (!m_axi_arvalid_o || cfg_q[15:8] != 8'h00);
	endproperty
	a_one_out: assert property (p_one_out) else $error("too many bursts in flight");
	property p_pix_hold;
		s_pix_wait |=> pix_valid_o
			&& $stable({pix_r_o, pix_g_o, pix_b_o, pix_a_o, pix_last_o});
	endproperty
	a_pix_hold: assert property (p_pix_hold) else $error("pixel lost while stalled");
	property p_fill_noread;
		win_q == 32'hFFFF_FFFF && step_q == 32'h0
			&& ctrl_q[`CTRL_OUTSIDE_SEL] == `FILL_WITH_FIXED |-> !m_axi_arvalid_o;
	endproperty
	a_fill_noread: assert property (p_fill_noread) else $error("read in fill frame");
	property p_last;
		pix_valid_o |-> pix_last_o == (cnt_q == {16'h0, dim_q[15:0]} * {16'h0, dim_q[31:16]} - 1);
	endproperty
	a_last: assert property (p_last) else $error("frame end at wrong count");
	property p_zero_b;
		pix_valid_o && cw_q[11:8] == 4'h0 && ctrl_q[10:5] == 6'h00 |-> pix_b_o == fc_q[23:16];
	endproperty
	a_zero_b: assert property (p_zero_b) else $error("empty component not fixed");
	property p_reset;
		disable iff (1'b0) reset_i |=> !pix_valid_o && !m_axi_arvalid_o && !m_axi_rready_o;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule // fetch_unit_sva

bind display_buffer_fetch_unit fetch_unit_sva chk (.*);

// ===== axi_mem_model.sv
`timescale 1ns/1ns
// ****
// Memory behind the read channel
// ****
module axi_mem_model (
	input  wire        core_clk_i,
	input  wire        reset_i,
	input  wire        slow_i,
	input  wire [31:0] araddr_i,
	input  wire [7:0]  arlen_i,
	input  wire        arvalid_i,
	output reg         arready_o,
	output reg  [31:0] rdata_o,
	output reg         rvalid_o,
	output reg         rlast_o,
	input  wire        rready_i
);
	integer    seed = 32'h3939;
	reg [31:0] rnd, addr_q;
	reg [8:0]  left_q, lnext;
	reg [3:0]  wait_q;
	function [31:0] mw(input [31:0] a);
		mw = {a[9:2] ^ 8'h3C, a[7:0] + 8'h11, ~a[9:2], a[9:2]};
	endfunction
	always @(posedge core_clk_i) begin
		rnd = $random(seed);
		lnext = left_q - {8'h0, rvalid_o && rready_i};
		if (reset_i) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b0;
			rlast_o <= 1'b0;
			rdata_o <= 32'h0;
			left_q <= 9'h0;
			wait_q <= 4'h0;
		end else begin
			arready_o <= arvalid_i && !arready_o && left_q == 9'h0 && (!slow_i || rnd[1]);
			if (arvalid_i && arready_o) begin
				addr_q <= araddr_i;
				wait_q <= slow_i ? {1'b0, rnd[6:4]} : 4'h0;
			end else if (wait_q != 4'h0)
				wait_q <= wait_q - 4'h1;
			left_q <= (arvalid_i && arready_o) ? {1'b0, arlen_i} + 9'h1 : lnext;
			if (rvalid_o && !rready_i) begin
			end else if (lnext != 9'h0 && wait_q == 4'h0 && (!slow_i || rnd[0])) begin
				rvalid_o <= 1'b1;
				rlast_o <= lnext == 9'h1;
				rdata_o <= mw(addr_q);
				addr_q <= addr_q + 32'h4;
			end else begin
				// Released data inverts each cycle, so every second idle cycle repeats the last beat
				rvalid_o <= 1'b0;
				rlast_o <= 1'b0;
				rdata_o <= ~rdata_o;
			end
		end
	end
endmodule // axi_mem_model

// ===== display_buffer_fetch_unit_bench.sv
`timescale 1ns/1ns
`include "fetch_unit_map.vh"
// ****
// Bench
// ****
module display_buffer_fetch_unit_bench;
	reg         core_clk_i = 1'b0;
	reg         reset_i = 1'b1;
	reg  [5:0]  reg_addr_i = 6'h00;
	reg  [31:0] reg_wdata_i = 32'h0;
	reg         reg_wr_i = 1'b0;
	reg         reg_rd_i = 1'b0;
	reg         pix_ready_i = 1'b0;
	reg         slow = 1'b0;
	wire [31:0] reg_rdata_o, araddr, rdata;
	wire [7:0]  arlen, pix_r_o, pix_g_o, pix_b_o, pix_a_o;
	wire        arvalid, arready, rvalid, rlast, rready, pix_valid_o, pix_last_o;
	integer     seed = 32'h3939;
	integer     err_count = 0;
	integer     total_checks = 0;
	integer     ar_cnt = 0;
	integer     w, h, wx, wy, hs, hx, hy, hw, hh, inv, hsel, stride, fill, x, y, i, k;
	reg  [31:0] fc, base, cw, ctl, rv;
	display_buffer_fetch_unit #(.BURST_AW(4)) dut (.*, .m_axi_araddr_o(araddr),
		.m_axi_arlen_o(arlen), .m_axi_arsize_o(), .m_axi_arburst_o(), .m_axi_arvalid_o(arvalid),
		.m_axi_arready_i(arready), .m_axi_rdata_i(rdata), .m_axi_rvalid_i(rvalid),
		.m_axi_rlast_i(rlast), .m_axi_rready_o(rready));
	axi_mem_model mem (.core_clk_i(core_clk_i), .reset_i(reset_i), .slow_i(slow),
		.araddr_i(araddr), .arlen_i(arlen), .arvalid_i(arvalid), .arready_o(arready),
		.rdata_o(rdata), .rvalid_o(rvalid), .rlast_o(rlast), .rready_i(rready));
	always #4 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		pix_ready_i <= ^$random(seed);
		if (arvalid === 1'b1 && arready === 1'b1) ar_cnt = ar_cnt + 1;
	end
	task conclude;
		begin
			$display("checks %0d errors %0d", total_checks, err_count);
			if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
			else $display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("wrong value %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [5:0] a, input [31:0] d);
		begin
			@(posedge core_clk_i);
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_wr_i <= 1'b1;
			@(posedge core_clk_i);
			reg_wr_i <= 1'b0;
		end
	endtask
	task rd(input [5:0] a, output [31:0] d);
		begin
			@(posedge core_clk_i);
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
			@(posedge core_clk_i);
			reg_rd_i <= 1'b0;
			@(negedge core_clk_i);
			d = reg_rdata_o;
		end
	endtask
	function [31:0] mw(input [31:0] a);
		mw = {a[9:2] ^ 8'h3C, a[7:0] + 8'h11, ~a[9:2], a[9:2]};
	endfunction
	function [31:0] expect_pix(input integer px, input integer py);
		reg [31:0] wd;
		begin
			wd = mw(base + (wy + py) * stride + (wx + px * hs) * 4);
			if (cw[11:8] == 4'h0) wd[23:16] = fc[23:16];
			if (ctl[9:8] == `SCALE_BY_FIXED)
				wd = wd & {{8{fc[31]}}, {8{fc[23]}}, {8{fc[15]}}, {8{fc[7]}}};
			if (fill != 0) expect_pix = fc;
			else if (((px >= hx && px < hx + hw && py >= hy && py < hy + hh) ^ inv) != 0)
				expect_pix = (hsel != 0) ? 32'h0 : fc;
			else expect_pix = wd;
		end
	endfunction
	task frame;
		begin
			wr(`REG_START_ADDR, base);
			wr(`REG_STRIDE, stride);
			wr(`REG_LINE_DIM, {16'd10, 16'd12});
			wr(`REG_DEPTH, 32'h0000_0020);
			wr(`REG_COMP_WIDTH, cw);
			wr(`REG_FIXED_COLOUR, fc);
			wr(`REG_OUT_DIM, {h[15:0], w[15:0]});
			wr(`REG_WINDOW_POS, (fill != 0) ? 32'hFFFF_FFFF : {wy[15:0], wx[15:0]});
			wr(`REG_STEP, (fill != 0) ? 32'h0 : {16'h0001, hs[15:0]});
			wr(`REG_HOLE_POS, {hy[15:0], hx[15:0]});
			wr(`REG_HOLE_DIM, {hh[15:0], hw[15:0]});
			ar_cnt = 0;
			wr(`REG_CTRL, ctl | 32'h1);
			for (y = 0; y < h; y = y + 1)
				for (x = 0; x < w; x = x + 1) begin
					i = 0;
					@(negedge core_clk_i);
					while (!(pix_valid_o === 1'b1 && pix_ready_i === 1'b1) && i < 3000) begin
						@(negedge core_clk_i);
						i = i + 1;
					end
					chk("pixel", expect_pix(x, y), {pix_a_o, pix_b_o, pix_g_o, pix_r_o});
					chk("last", (x == w - 1 && y == h - 1) ? 32'h1 : 32'h0, {31'h0, pix_last_o});
				end
			rv = 32'h1;
			for (i = 0; i < 40 && rv[0] !== 1'b0; i = i + 1)
				rd(`REG_STATUS, rv);
			chk("valid after frame", 32'h0, {31'h0, pix_valid_o});
			if (fill != 0) chk("read count", 32'h0, ar_cnt);
		end
	endtask
	initial begin
		{fc, base, ctl, wx, wy, hx, hy, hw, hh, inv, hsel} = 0;
		cw = 32'h0000_8888;
		hs = 1;
		stride = 64;
		repeat (8) @(posedge core_clk_i);
		reset_i <= 1'b0;
		rd(`REG_AXI_CFG, rv);
		chk("axi config", {16'h0, `RST_OUT_BUFS, 3'h0, `RST_BURST_LEN}, rv);
		rd(`REG_COMP_WIDTH, rv);
		chk("comp widths", {16'h0, `RST_COMP_WIDTH}, rv);
		rd(`REG_COMP_POS, rv);
		chk("comp positions", `RST_COMP_POS, rv);
		wr(6'h3F, 32'hFFFF_FFFF);
		rd(6'h3F, rv);
		chk("unmapped", 32'h0, rv);
		for (k = 0; k < 3; k = k + 1) begin
			fill = 1;
			w = 1 + {$random(seed)} % 6;
			h = 1 + {$random(seed)} % 4;
			fc = $random(seed);
			frame;
		end
		fill = 0;
		wr(`REG_AXI_CFG, 32'h0000_0802);
		for (k = 0; k < 2; k = k + 1) begin
			slow = k[0];
			wx = {$random(seed)} % 4;
			wy = {$random(seed)} % 4;
			w = 2 + {$random(seed)} % 5;
			h = 2 + {$random(seed)} % 4;
			stride = 48 + 16 * ({$random(seed)} % 3);
			base = $random(seed) & 32'h0000_FFC0;
			cw = 32'h0000_8088;
			fc = $random(seed);
			frame;
		end
		wr(`REG_AXI_CFG, 32'h0000_0404);
		cw = 32'h0000_8888;
		hs = -1;
		wx = w - 1 + {$random(seed)} % 4;
		fc = 32'h00FF_00FF;
		ctl = {30'h0, `SCALE_BY_FIXED} << `CTRL_SCALE_LO;
		frame;
		{wx, wy, ctl} = 0;
		hs = 1;
		w = 6;
		h = 4;
		for (inv = 0; inv < 2; inv = inv + 1) begin
			hx = 1 + {$random(seed)} % 2;
			hy = 1;
			hw = 2;
			hh = 2;
			hsel = 1;
			ctl = (inv << `CTRL_HOLE_INVERT) | (32'h1 << `CTRL_HOLE_SEL);
			frame;
		end
		conclude;
	end
	initial begin
		repeat (60000) @(posedge core_clk_i);
		err_count = err_count + 1;
		conclude;
	end
endmodule // display_buffer_fetch_unit_bench
